// ### logic/eicst_pkg.sv
// Constants, carriers and register map of the edge interrupt and context stack block.
// Assumes a 125 MHz core clock and a core that signals instruction cycles by an enable.
package eicst_pkg;

    // ==========================================================================
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int PULSE_REJECT_US = 1;
    localparam int REJECT_CYCLES = PULSE_REJECT_US * CLK_MHZ;
    localparam int TICK_MS = 5;
    localparam int BASE_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICKS_100MS = 100 / TICK_MS;
    localparam int TICKS_20MS = 20 / TICK_MS;
    localparam int TICKS_5MS = 5 / TICK_MS;

    // ==========================================================================
    // Sizes
    localparam int PC_W = 12;
    localparam int ASTACK_DEPTH = 6;
    localparam int ISTACK_DEPTH = 2;

    // ==========================================================================
    // Register indices; byte address is four times the index
    localparam logic [5:0] REG_TIMER_MODE = 6'h09;
    localparam logic [5:0] REG_STATUS = 6'h0e;
    localparam logic [5:0] REG_PIN_LEVEL = 6'h0f;
    localparam logic [5:0] REG_EDGE_SEL = 6'h1f;
    localparam logic [5:0] REG_PERMIT = 6'h2f;
    localparam logic [5:0] REG_REQUEST = 6'h3f;

    // ==========================================================================
    // Field positions
    localparam int PIN_REMOTE = 0;
    localparam int PIN_FRAME = 1;
    localparam int SRC_REMOTE = 0;
    localparam int SRC_TIMER = 1;
    localparam int SRC_FRAME = 2;
    localparam int SRC_SERIAL = 3;
    localparam int STAT_GIE = 0;
    localparam int STAT_EI_PEND = 1;
    localparam int STAT_DEPTH = 2;

    // ==========================================================================
    // Reset values and vectors
    localparam logic [1:0] EDGE_SEL_RST = 2'h0;
    localparam logic [3:0] PERMIT_RST = 4'h0;
    localparam logic [2:0] ASP_RST = 3'h6;
    localparam logic [PC_W-1:0] VEC_REMOTE = 12'h001;
    localparam logic [PC_W-1:0] VEC_TIMER = 12'h002;
    localparam logic [PC_W-1:0] VEC_FRAME = 12'h003;
    localparam logic [PC_W-1:0] VEC_SERIAL = 12'h004;

    typedef enum logic [1:0] {
        TM_100MS = 2'b00,
        TM_20MS = 2'b01,
        TM_5MS = 2'b10
    } eicst_tmode_type;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic instr_cycle;
        logic int_ok;
        logic ei;
        logic di;
        logic call;
        logic ret;
        logic return_from_interrupt;
        logic [PC_W-1:0] pc;
        logic bank_wr;
        logic [1:0] bank;
        logic ixe_wr;
        logic index_enable_flag;
    } eicst_core_req_type;

    typedef struct packed {
        logic accept;
        logic pc_load;
        logic [PC_W-1:0] pc;
        logic [1:0] bank;
        logic index_enable_flag;
        logic [1:0] source;
    } eicst_core_rsp_type;

endpackage

// ### logic/eicst_top.sv
// Edge interrupt controller with two-level context stack and address stack.
// Assumes a classic Wishbone master, a core that pulses instr_cycle once per
// instruction, and asynchronous pin inputs.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns

module eicst_top
    import eicst_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = BASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic remote_irq_pin_i,
    input wire logic frame_pin_i,
    input wire logic serial_done_i,
    input wire eicst_core_req_type core_i,
    output eicst_core_rsp_type core_o,
    output logic irq_o
);

    // ==========================================================================
    // State
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] filt;
        logic [1:0][7:0] fcnt;
        logic [1:0] act;
        logic [1:0] edge_sel;
        logic [3:0] permit;
        logic [3:0] req;
        logic [1:0] tmode;
        logic [19:0] base_cnt;
        logic [4:0] tick_cnt;
        logic gie;
        logic ei_pend;
        logic [1:0] bank;
        logic index_enable_flag;
        logic [ISTACK_DEPTH-1:0][2:0] istk;
        logic [1:0] idepth;
        logic [ASTACK_DEPTH-1:0][PC_W-1:0] astk;
        logic [2:0] asp;
        eicst_core_rsp_type rsp;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } eicst_state_type;

    eicst_state_type s_q;
    eicst_state_type s_d;

    // ==========================================================================
    // Helpers
    function automatic logic [3:0] eicst_pick(input logic [3:0] pend);
        logic [3:0] one;
        one = 4'h0;
        if (pend[SRC_REMOTE]) begin
            one[SRC_REMOTE] = 1'b1;
        end else if (pend[SRC_TIMER]) begin
            one[SRC_TIMER] = 1'b1;
        end else if (pend[SRC_FRAME]) begin
            one[SRC_FRAME] = 1'b1;
        end else if (pend[SRC_SERIAL]) begin
            one[SRC_SERIAL] = 1'b1;
        end
        return one;
    endfunction

    function automatic logic [4:0] eicst_tick_limit(input logic [1:0] mode);
        logic [4:0] lim;
        case (eicst_tmode_type'(mode))
            TM_100MS: begin
                lim = 5'(TICKS_100MS);
            end
            TM_20MS: begin
                lim = 5'(TICKS_20MS);
            end
            TM_5MS: begin
                lim = 5'(TICKS_5MS);
            end
            default: begin
                lim = 5'(TICKS_100MS);
            end
        endcase
        return lim;
    endfunction

    function automatic logic eicst_hit(input logic [5:0] idx, input logic [5:0] reg_idx);
        return idx == reg_idx;
    endfunction

    function automatic logic [PC_W-1:0] eicst_vector(input logic [1:0] src);
        logic [PC_W-1:0] v;
        case (src)
            2'(SRC_TIMER): begin
                v = VEC_TIMER;
            end
            2'(SRC_FRAME): begin
                v = VEC_FRAME;
            end
            2'(SRC_SERIAL): begin
                v = VEC_SERIAL;
            end
            default: begin
                v = VEC_REMOTE;
            end
        endcase
        return v;
    endfunction

    // ==========================================================================
    // Next state
    always_comb begin
        logic bus_req;
        logic bus_wr;
        logic [5:0] idx;
        logic [3:0] set;
        logic [3:0] clr;
        logic [3:0] pick;
        logic base_tick;
        logic [1:0] pin_raw;
        logic accept;
        logic [PC_W-1:0] vec;
        logic [2:0] top;
        logic restart;
        bus_req = 1'b0;
        bus_wr = 1'b0;
        idx = 6'h00;
        set = 4'h0;
        clr = 4'h0;
        pick = 4'h0;
        base_tick = 1'b0;
        pin_raw = 2'h0;
        accept = 1'b0;
        vec = VEC_REMOTE;
        top = 3'h0;
        restart = 1'b0;
        s_d = s_q;
        s_d.rsp.accept = 1'b0;
        s_d.rsp.pc_load = 1'b0;

        // ==========================================================================
        // Bus slave: one wait state, unmapped indices read zero and ignore writes.
        bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
        bus_wr = bus_req & wb_we_i & wb_sel_i[0];
        idx = wb_adr_i[7:2];
        s_d.ack = bus_req;
        s_d.dat = 32'h0000_0000;
        if (bus_req & ~wb_we_i) begin
            if (eicst_hit(idx, REG_PIN_LEVEL)) begin
                s_d.dat = {30'h0, s_q.filt};
            end else if (eicst_hit(idx, REG_EDGE_SEL)) begin
                s_d.dat = {30'h0, s_q.edge_sel};
            end else if (eicst_hit(idx, REG_PERMIT)) begin
                s_d.dat = {28'h0, s_q.permit};
            end else if (eicst_hit(idx, REG_REQUEST)) begin
                s_d.dat = {28'h0, s_q.req};
            end else if (eicst_hit(idx, REG_TIMER_MODE)) begin
                s_d.dat = {30'h0, s_q.tmode};
            end else if (eicst_hit(idx, REG_STATUS)) begin
                s_d.dat = {28'h0, s_q.idepth, s_q.ei_pend, s_q.gie};
            end
        end
        if (bus_wr) begin
            if (eicst_hit(idx, REG_EDGE_SEL)) begin
                s_d.edge_sel = wb_dat_i[1:0];
            end
            if (eicst_hit(idx, REG_PERMIT)) begin
                s_d.permit = wb_dat_i[3:0];
            end
            if (eicst_hit(idx, REG_REQUEST)) begin
                clr = wb_dat_i[3:0];
            end
            if (eicst_hit(idx, REG_TIMER_MODE)) begin
                s_d.tmode = wb_dat_i[1:0];
                restart = 1'b1;
            end
        end

        // ==========================================================================
        // Pins: synchronise, reject short pulses, then detect the selected edge.
        pin_raw[PIN_REMOTE] = remote_irq_pin_i;
        pin_raw[PIN_FRAME] = frame_pin_i;
        // Two flops settle a pin that may move at any moment against the clock.
        s_d.sync1 = pin_raw;
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < 2; i++) begin
            // A pulse shorter than the reject span resets the counter and leaves no trace.
            if (s_q.sync2[i] != s_q.filt[i]) begin
                if (s_q.fcnt[i] == 8'(REJECT_CYCLES)) begin
                    s_d.filt[i] = s_q.sync2[i];
                    s_d.fcnt[i] = 8'h00;
                end else begin
                    s_d.fcnt[i] = s_q.fcnt[i] + 8'h01;
                end
            end else begin
                s_d.fcnt[i] = 8'h00;
            end
            // Level xor select is the active signal; a select write moves it too.
            s_d.act[i] = s_d.filt[i] ^ s_d.edge_sel[i];
        end
        set[SRC_REMOTE] = s_d.act[PIN_REMOTE] & ~s_q.act[PIN_REMOTE];
        set[SRC_FRAME] = s_d.act[PIN_FRAME] & ~s_q.act[PIN_FRAME];

        // ==========================================================================
        // Timer: a fixed base tick, counted up to the selected interval.
        // A mode write restarts both counters, so the first interval is whole.
        if (restart) begin
            s_d.base_cnt = 20'h00000;
            s_d.tick_cnt = 5'h00;
        end else if (s_q.base_cnt == 20'(BASE_TICK_CYCLES - 1)) begin
            s_d.base_cnt = 20'h00000;
            base_tick = 1'b1;
        end else begin
            s_d.base_cnt = s_q.base_cnt + 20'h00001;
        end
        if (base_tick) begin
            if (s_q.tick_cnt >= eicst_tick_limit(s_q.tmode) - 5'h01) begin
                s_d.tick_cnt = 5'h00;
                set[SRC_TIMER] = 1'b1;
            end else begin
                s_d.tick_cnt = s_q.tick_cnt + 5'h01;
            end
        end
        set[SRC_SERIAL] = serial_done_i;

        // ==========================================================================
        // Global enable, with the one-cycle delay after the enable instruction.
        if (core_i.instr_cycle) begin
            if (core_i.di) begin
                s_d.gie = 1'b0;
                s_d.ei_pend = 1'b0;
            end else if (s_q.ei_pend) begin
                s_d.gie = 1'b1;
                s_d.ei_pend = core_i.ei;
            end else if (core_i.ei) begin
                s_d.ei_pend = 1'b1;
            end
        end

        // ==========================================================================
        // Acceptance and returns; the core pulses at most one of these per cycle.
        pick = eicst_pick(s_q.req & s_q.permit);
        accept = core_i.instr_cycle & core_i.int_ok & s_q.gie & (|pick);
        if (core_i.instr_cycle & core_i.bank_wr) begin
            s_d.bank = core_i.bank;
        end
        if (core_i.instr_cycle & core_i.ixe_wr) begin
            s_d.index_enable_flag = core_i.index_enable_flag;
        end
        if (accept) begin
            if (pick[SRC_TIMER]) begin
                s_d.rsp.source = 2'(SRC_TIMER);
            end else if (pick[SRC_FRAME]) begin
                s_d.rsp.source = 2'(SRC_FRAME);
            end else if (pick[SRC_SERIAL]) begin
                s_d.rsp.source = 2'(SRC_SERIAL);
            end else begin
                s_d.rsp.source = 2'(SRC_REMOTE);
            end
            vec = eicst_vector(s_d.rsp.source);
            // Other status flags live in the core and are not touched here.
            s_d.gie = 1'b0;
            // Only two levels: a third push sweeps off the oldest entry, never rotates.
            s_d.istk[1] = s_q.istk[0];
            s_d.istk[0] = {s_q.bank, s_q.index_enable_flag};
            if (s_q.idepth != 2'(ISTACK_DEPTH)) begin
                s_d.idepth = s_q.idepth + 2'h1;
            end
            s_d.bank = 2'h0;
            s_d.index_enable_flag = 1'b0;
            // A push with the address stack full is lost; software bounds the nesting.
            top = s_q.asp - 3'h1;
            s_d.asp = top;
            if (top < 3'(ASTACK_DEPTH)) begin
                s_d.astk[top] = core_i.pc;
            end
            s_d.rsp.accept = 1'b1;
            s_d.rsp.pc_load = 1'b1;
            s_d.rsp.pc = vec;
        end else if (core_i.instr_cycle & core_i.call) begin
            top = s_q.asp - 3'h1;
            s_d.asp = top;
            if (top < 3'(ASTACK_DEPTH)) begin
                s_d.astk[top] = core_i.pc;
            end
        end else if (core_i.instr_cycle & (core_i.ret | core_i.return_from_interrupt)) begin
            s_d.rsp.pc_load = 1'b1;
            s_d.rsp.pc = (s_q.asp < 3'(ASTACK_DEPTH)) ? s_q.astk[s_q.asp] : '0;
            if (s_q.asp < 3'(ASTACK_DEPTH)) begin
                s_d.asp = s_q.asp + 3'h1;
            end
            if (core_i.return_from_interrupt) begin
                // An empty stack restores zero, since the lost entry is gone for good.
                s_d.bank = s_q.istk[0][2:1];
                s_d.index_enable_flag = s_q.istk[0][0];
                s_d.istk[0] = s_q.istk[1];
                s_d.istk[1] = 3'h0;
                if (s_q.idepth != 2'h0) begin
                    s_d.idepth = s_q.idepth - 2'h1;
                end
            end
        end

        // ==========================================================================
        // Request flags: a new edge beats a clear in the same cycle.
        clr[SRC_REMOTE] = clr[SRC_REMOTE] | (accept & pick[SRC_REMOTE]);
        clr[SRC_TIMER] = clr[SRC_TIMER] | (accept & pick[SRC_TIMER]);
        clr[SRC_FRAME] = clr[SRC_FRAME] | (accept & pick[SRC_FRAME]);
        clr[SRC_SERIAL] = clr[SRC_SERIAL] | (accept & pick[SRC_SERIAL]);
        s_d.req = (s_q.req & ~clr) | set;
        s_d.irq = |(s_d.req & s_d.permit);
        s_d.rsp.bank = s_d.bank;
        s_d.rsp.index_enable_flag = s_d.index_enable_flag;
    end

    // ==========================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.edge_sel <= EDGE_SEL_RST;
            s_q.permit <= PERMIT_RST;
            s_q.asp <= ASP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign core_o = s_q.rsp;
    assign irq_o = s_q.irq;

endmodule

// ### testbench/eicst_props.sv
// Checker of the core-side answers of the interrupt block.
// Assumes it is bound to eicst_top and reads only its ports.
`timescale 1ns/1ns
module eicst_props
    import eicst_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = BASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire eicst_core_req_type core_i,
    input wire eicst_core_rsp_type core_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ========
    // Sequences
    sequence s_vector;
        core_o.pc_load && core_o.pc == {10'h000, core_o.source} + 12'h001;
    endsequence
    sequence s_cleared;
        core_o.bank == 2'h0 && !core_o.index_enable_flag;
    endsequence
    // ========
    // Properties
    property p_cause;
        core_o.accept |-> $past(core_i.instr_cycle) && $past(core_i.int_ok);
    endproperty
    a_cause: assert property (p_cause)
        else $error("accept without a ready instruction cycle");
    property p_ctx;
        core_o.accept |-> s_cleared;
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("context not cleared on accept");
    property p_vec;
        core_o.accept |-> s_vector;
    endproperty
    a_vec: assert property (p_vec)
        else $error("wrong vector on accept");
    property p_single;
        core_o.accept |=> !core_o.accept;
    endproperty
    a_single: assert property (p_single)
        else $error("accept longer than one cycle");
    property p_return_from_interrupt;
        core_i.instr_cycle && core_i.return_from_interrupt |=> core_o.pc_load;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt)
        else $error("return without pc load");
    // A plain return must leave the current context alone; only acceptance may win.
    property p_ret;
        core_i.instr_cycle && core_i.ret && !core_i.bank_wr && !core_i.ixe_wr
            |=> core_o.accept || ($stable(core_o.bank) && $stable(core_o.index_enable_flag));
    endproperty
    a_ret: assert property (p_ret)
        else $error("plain return changed context");
    property p_hold;
        !core_o.accept && !$past(core_i.instr_cycle) && !$past(rst_i)
            |-> $stable(core_o.bank) && $stable(core_o.index_enable_flag);
    endproperty
    a_hold: assert property (p_hold)
        else $error("context changed without cause");
    property p_pc;
        !core_o.pc_load && !$past(rst_i) |-> $stable(core_o.pc);
    endproperty
    a_pc: assert property (p_pc)
        else $error("pc changed without load");
endmodule

bind eicst_top eicst_props #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .core_i(core_i), .core_o(core_o)
);

// ### testbench/eicst_pins.sv
// Model of the remote receiver and frame sync source driving the two pins.
// Assumes callers run in step with clk_i; the pins are push-pull, never released.
`timescale 1ns/1ns
module eicst_pins (
    input wire logic clk_i,
    output logic [1:0] pin_o
);
    initial pin_o = 2'h0;
    task automatic set_pin(input int which, input logic val);
        @(posedge clk_i);
        pin_o[which] <= val;
    endtask
    // Short glitches stand for line noise that must leave no trace.
    task automatic pulse(input int which, input int len);
        @(posedge clk_i);
        pin_o[which] <= ~pin_o[which];
        repeat (len) @(posedge clk_i);
        pin_o[which] <= ~pin_o[which];
    endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench of the interrupt block: bus, pins, timer and core port.
// Assumes the pin model eicst_pins and the checker bound to eicst_top.
`timescale 1ns/1ns
module testbench;
    import eicst_pkg::*;
    localparam int TICK = 20;
    logic clk_i, rst_i, cyc, stb, we, sdone, ack, irq;
    logic [1:0] pins;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, rd;
    eicst_core_req_type creq;
    eicst_core_rsp_type crsp, rsp;
    int err_count = 0;
    int checks = 0;
    int ticks[4] = '{TICKS_100MS, TICKS_20MS, TICKS_5MS, TICKS_100MS};
    logic [15:0] rt[3] = '{16'h9802, 16'h9004, 16'h8800};
    eicst_top #(.BASE_TICK_CYCLES(TICK)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .remote_irq_pin_i(pins[0]), .frame_pin_i(pins[1]), .serial_done_i(sdone),
        .core_i(creq), .core_o(crsp), .irq_o(irq)
    );
    eicst_pins i_pins (.clk_i(clk_i), .pin_o(pins));
    // ========
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input string name, input logic [5:0] idx, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        check(name, rd & m, e);
    endtask
    task automatic core_op(input int op, input logic ok, input logic [11:0] pc,
                           input logic [2:0] c);
        eicst_core_req_type r;
        r = '0;
        r.instr_cycle = 1'b1;
        r.int_ok = ok;
        r.pc = pc;
        r.ei = op == 1;
        r.return_from_interrupt = op == 2;
        r.bank_wr = op == 3;
        r.ixe_wr = op == 3;
        r.ret = op == 4;
        r.di = op == 5;
        r.call = op == 6;
        {r.bank, r.index_enable_flag} = c;
        @(posedge clk_i);
        creq <= r;
        @(posedge clk_i);
        creq <= '0;
        @(negedge clk_i);
        rsp = crsp;
    endtask
    task automatic take(input logic [11:0] pc, input logic [2:0] c, input logic [11:0] v,
                        input logic [1:0] s);
        core_op(3, 1'b0, 12'h000, c);
        core_op(1, 1'b0, 12'h000, 3'h0);
        core_op(0, 1'b1, pc, 3'h0);
        check("early accept", 32'(rsp.accept), 32'h0);
        core_op(0, 1'b1, pc, 3'h0);
        check("accept", 32'(rsp), 32'(eicst_core_rsp_type'{1'b1, 1'b1, v, 2'h0, 1'b0, s}));
    endtask
    task automatic serial();
        @(posedge clk_i);
        sdone <= 1'b1;
        @(posedge clk_i);
        sdone <= 1'b0;
    endtask
    task automatic irqc(input logic e);
        @(negedge clk_i);
        check("irq", 32'(irq), 32'(e));
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ========
    // Clock, watchdog and tests
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, sdone} = 4'h0;
        adr = 8'h00;
        wdat = 32'h0;
        creq = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("edge sel", REG_EDGE_SEL, 32'hf, 32'h0);
        rdc("permit", REG_PERMIT, 32'hf, 32'h0);
        rdc("status", REG_STATUS, 32'hf, 32'h0);
        rdc("unmapped", 6'h00, 32'hffffffff, 32'h0);
        bus(1'b1, REG_PIN_LEVEL, 32'h3);
        i_pins.pulse(1, 125);
        repeat (200) @(posedge clk_i);
        rdc("glitch req", REG_REQUEST, 32'hd, 32'h0);
        rdc("glitch level", REG_PIN_LEVEL, 32'hf, 32'h0);
        i_pins.set_pin(0, 1'b1);
        i_pins.set_pin(1, 1'b1);
        repeat (200) @(posedge clk_i);
        rdc("level", REG_PIN_LEVEL, 32'hf, 32'h3);
        rdc("rise", REG_REQUEST, 32'hd, 32'h5);
        bus(1'b1, REG_REQUEST, 32'hf);
        bus(1'b1, REG_EDGE_SEL, 32'h3);
        rdc("sel high to fall", REG_REQUEST, 32'hd, 32'h0);
        bus(1'b1, REG_EDGE_SEL, 32'h1);
        rdc("sel high to rise", REG_REQUEST, 32'hd, 32'h4);
        i_pins.set_pin(0, 1'b0);
        i_pins.set_pin(1, 1'b0);
        repeat (200) @(posedge clk_i);
        rdc("fall", REG_REQUEST, 32'hd, 32'h5);
        bus(1'b1, REG_REQUEST, 32'h5);
        bus(1'b1, REG_EDGE_SEL, 32'h0);
        rdc("sel low to rise", REG_REQUEST, 32'hd, 32'h0);
        bus(1'b1, REG_EDGE_SEL, 32'h1);
        rdc("sel low to fall", REG_REQUEST, 32'hd, 32'h1);
        serial();
        rdc("serial", REG_REQUEST, 32'hd, 32'h9);
        bus(1'b1, REG_PERMIT, 32'h8);
        irqc(1'b1);
        bus(1'b1, REG_PERMIT, 32'h0);
        irqc(1'b0);
        bus(1'b1, REG_PERMIT, 32'h8);
        bus(1'b1, REG_REQUEST, 32'h8);
        irqc(1'b0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, REG_TIMER_MODE, 32'(m));
            bus(1'b1, REG_REQUEST, 32'h2);
            repeat (ticks[m] * TICK - 12) @(posedge clk_i);
            rdc("timer early", REG_REQUEST, 32'h2, 32'h0);
            repeat (14) @(posedge clk_i);
            rdc("timer due", REG_REQUEST, 32'h2, 32'h2);
        end
        bus(1'b1, REG_TIMER_MODE, 32'h0);
        bus(1'b1, REG_REQUEST, 32'hf);
        bus(1'b1, REG_EDGE_SEL, 32'h0);
        bus(1'b1, REG_EDGE_SEL, 32'h1);
        serial();
        bus(1'b1, REG_PERMIT, 32'h9);
        take(12'h100, 3'h7, VEC_REMOTE, 2'(SRC_REMOTE));
        rdc("req cleared", REG_REQUEST, 32'hd, 32'h8);
        rdc("depth one", REG_STATUS, 32'hf, 32'h4);
        take(12'h200, 3'h4, VEC_SERIAL, 2'(SRC_SERIAL));
        serial();
        take(12'h300, 3'h2, VEC_SERIAL, 2'(SRC_SERIAL));
        rdc("depth two", REG_STATUS, 32'hf, 32'h8);
        for (int i = 0; i < 3; i++) begin
            core_op(2, 1'b0, 12'h000, 3'h0);
            check("return_from_interrupt", 32'({rsp.pc_load, rsp.pc, rsp.bank, rsp.index_enable_flag}), 32'(rt[i]));
        end
        core_op(3, 1'b0, 12'h000, 3'h5);
        core_op(4, 1'b0, 12'h000, 3'h0);
        check("ret", 32'({rsp.pc_load, rsp.pc, rsp.bank, rsp.index_enable_flag}), 32'h8005);
        core_op(6, 1'b0, 12'h123, 3'h0);
        core_op(4, 1'b0, 12'h000, 3'h0);
        check("call ret", 32'({rsp.pc_load, rsp.pc, rsp.bank, rsp.index_enable_flag}), 32'h891d);
        core_op(1, 1'b0, 12'h000, 3'h0);
        rdc("ei pending", REG_STATUS, 32'hf, 32'h2);
        core_op(5, 1'b0, 12'h000, 3'h0);
        rdc("di", REG_STATUS, 32'hf, 32'h0);
        print_verdict();
    end
endmodule
